// ---- rtl/hpc_defines.svh ----
// Purpose: Constants for hub port charge power control
// Assumes: Included by bare name
// Notes: Offsets, positions and reset values
`ifndef HPC_DEFINES_SVH
`define HPC_DEFINES_SVH
`define HPC_CHARGE_ENABLE_ADDR 8'hd0
`define HPC_DETECT_STATUS_ADDR 8'hd1
`define HPC_CHARGE_ENABLE_RESET 8'h00
`define HPC_FIRST_PORT_BIT 1
`define HPC_DETECT_FILTER 4'h8
`endif

// ---- rtl/hpc_pkg.sv ----
// Purpose: Types for hub port charge power control
// Assumes: Three downstream ports by default
// Notes: Types only
package hpc_pkg;
  typedef enum logic [1:0] {
    HPC_CFG_WAIT,
    HPC_CHARGE_CTRL,
    HPC_HUB_CTRL
  } hpc_mode_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } hpc_cfg_wr_t;
  typedef struct packed {
    logic dp_oe;
    logic dp_out;
    logic dm_oe;
    logic dm_out;
  } hpc_detect_drive_t;
endpackage : hpc_pkg

// ---- rtl/hpc_sync.sv ----
// Purpose: Two flip-flop synchroniser bank
// Assumes: Inputs asynchronous to clk
// Notes: First stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module hpc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= INIT;
      q_reg <= INIT;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule : hpc_sync
`default_nettype wire

// ---- rtl/hpc_top.sv ----
// Purpose: Per-port power control for charging downstream ports
// Assumes: Config writes arrive on clk; pins are asynchronous
// Notes: Notes below
`timescale 1ns/1ps
`default_nettype none
`include "hpc_defines.svh"
module hpc_top
  import hpc_pkg::*;
#(
  parameter int PORTS = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire hpc_cfg_wr_t cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_rd_addr,
  output logic [7:0] cfg_rd_data,
  input wire logic cfg_done,
  input wire logic enumerated,
  input wire logic [PORTS-1:0] hub_port_power_feature,
  input wire logic [PORTS-1:0] hub_power_request,
  input wire logic [PORTS-1:0] overcurrent_sense_low,
  input wire logic upstream_plus_pin_in,
  input wire logic upstream_minus_pin_in,
  output logic upstream_plus_pin_out,
  output logic upstream_plus_pin_oe,
  output logic upstream_minus_pin_out,
  output logic upstream_minus_pin_oe,
  input wire logic [PORTS-1:0] charge_query,
  output logic [PORTS-1:0] charge_ack,
  output logic [PORTS-1:0] port_power_enable,
  output logic charger_detected,
  output logic regulator_3v3
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [PORTS-1:0] oc_low_sync;
  logic [1:0] pins_sync;
  logic [PORTS-1:0] query_sync;
  hpc_sync #(.WIDTH(PORTS), .INIT({PORTS{1'b1}})) u_oc_sync (
    .clk(clk),
    .nrst(nrst),
    .d(overcurrent_sense_low),
    .q(oc_low_sync)
  );
  hpc_sync #(.WIDTH(2), .INIT(2'h0)) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .d({upstream_plus_pin_in, upstream_minus_pin_in}),
    .q(pins_sync)
  );
  hpc_sync #(.WIDTH(PORTS), .INIT('0)) u_query_sync (
    .clk(clk),
    .nrst(nrst),
    .d(charge_query),
    .q(query_sync)
  );
  // ----------------------------------------
  // Charge enable register
  // ----------------------------------------
  logic [7:0] charge_enable_mask_reg, charge_enable_mask_next;
  hpc_mode_t mode_reg, mode_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic [PORTS-1:0] port_charge;
  logic detected_reg, detected_next;

  function automatic logic is_mask_addr(input logic [7:0] addr);
    is_mask_addr = (addr == `HPC_CHARGE_ENABLE_ADDR);
  endfunction : is_mask_addr

  function automatic logic is_status_addr(input logic [7:0] addr);
    is_status_addr = (addr == `HPC_DETECT_STATUS_ADDR);
  endfunction : is_status_addr

  always_comb begin
    charge_enable_mask_next = charge_enable_mask_reg;
    // Mask writable only before configuration completes
    if (mode_reg == HPC_CFG_WAIT && cfg_wr.wr) begin
      if (is_mask_addr(cfg_wr.addr)) begin
        charge_enable_mask_next = cfg_wr.data;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      charge_enable_mask_reg <= `HPC_CHARGE_ENABLE_RESET;
    end else begin
      charge_enable_mask_reg <= charge_enable_mask_next;
    end
  end

  // ----------------------------------------
  // Control mode
  // ----------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      HPC_CFG_WAIT: begin
        if (cfg_done) begin
          mode_next = HPC_CHARGE_CTRL;
        end
      end
      HPC_CHARGE_CTRL: begin
        if (enumerated) begin
          mode_next = HPC_HUB_CTRL;
        end
      end
      HPC_HUB_CTRL: begin
        mode_next = HPC_HUB_CTRL;
      end
      default: begin
        mode_next = HPC_CFG_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= HPC_CFG_WAIT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_comb begin
    rd_data_next = rd_data_reg;
    if (cfg_rd) begin
      if (is_mask_addr(cfg_rd_addr)) begin
        rd_data_next = charge_enable_mask_reg;
      end else if (is_status_addr(cfg_rd_addr)) begin
        rd_data_next = {7'h00, detected_reg};
      end else begin
        rd_data_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ----------------------------------------
  // Overcurrent latch
  // ----------------------------------------
  logic [PORTS-1:0] oc_latch_reg, oc_latch_next;
  logic [PORTS-1:0] oc_now;
  always_comb begin
    oc_now = ~oc_low_sync;
    if (mode_reg == HPC_HUB_CTRL) begin
      oc_latch_next = oc_now;
    end else begin
      oc_latch_next = oc_latch_reg | oc_now;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_latch_reg <= '0;
    end else begin
      oc_latch_reg <= oc_latch_next;
    end
  end

  // ----------------------------------------
  // Per-port power control
  // ----------------------------------------
  logic [PORTS-1:0] power_reg, power_next;
  logic [PORTS-1:0] ack_reg, ack_next;
  logic [PORTS-1:0] charge_owner;
  logic [PORTS-1:0] hub_owner;
  logic [PORTS-1:0] oc_block;
  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++) begin : g_port
      assign port_charge[gi] = charge_enable_mask_reg[gi + `HPC_FIRST_PORT_BIT];
      assign charge_owner[gi] = port_charge[gi] && !hub_port_power_feature[gi] && mode_reg != HPC_HUB_CTRL;
      assign hub_owner[gi] = hub_port_power_feature[gi] || mode_reg == HPC_HUB_CTRL;
      // Charge-mode latch no longer blocks once mode_reg reaches HPC_HUB_CTRL
      assign oc_block[gi] = oc_now[gi] | (oc_latch_reg[gi] && mode_reg != HPC_HUB_CTRL);
      always_comb begin
        if (oc_block[gi]) begin
          power_next[gi] = 1'b0;
        end else if (charge_owner[gi]) begin
          power_next[gi] = (mode_reg == HPC_CHARGE_CTRL);
        end else if (hub_owner[gi]) begin
          power_next[gi] = hub_power_request[gi];
        end else begin
          power_next[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // Positive answer only, never a negative one
  always_comb begin
    ack_next = '0;
    for (int i = 0; i < PORTS; i++) begin
      if (port_charge[i] && mode_reg != HPC_CFG_WAIT && query_sync[i]) begin
        ack_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_reg <= '0;
      ack_reg <= '0;
    end else begin
      power_reg <= power_next;
      ack_reg <= ack_next;
    end
  end

  // ----------------------------------------
  // Charger detection on upstream pins
  // ----------------------------------------
  logic [3:0] det_cnt_reg, det_cnt_next;
  logic drive_reg, drive_next;
  always_comb begin
    det_cnt_next = det_cnt_reg;
    detected_next = detected_reg;
    drive_next = (mode_reg == HPC_CFG_WAIT) && !detected_reg;
    if (drive_reg && pins_sync[0]) begin
      if (det_cnt_reg == `HPC_DETECT_FILTER) begin
        detected_next = 1'b1;
      end else begin
        det_cnt_next = det_cnt_reg + 4'h1;
      end
    end else begin
      det_cnt_next = 4'h0;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      det_cnt_reg <= 4'h0;
      detected_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      det_cnt_reg <= det_cnt_next;
      detected_reg <= detected_next;
      drive_reg <= drive_next;
    end
  end
  // ----------------------------------------
  // Regulator enable
  // ----------------------------------------
  logic reg_on_reg, reg_on_next;
  always_comb begin
    reg_on_next = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_on_reg <= 1'b0;
    end else begin
      reg_on_reg <= reg_on_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign upstream_plus_pin_out = drive_reg;
  assign upstream_plus_pin_oe = drive_reg;
  assign upstream_minus_pin_out = 1'b0;
  assign upstream_minus_pin_oe = 1'b0;
  assign cfg_rd_data = rd_data_reg;
  assign charge_ack = ack_reg;
  assign port_power_enable = power_reg;
  assign charger_detected = detected_reg;
  assign regulator_3v3 = reg_on_reg;
endmodule : hpc_top
`default_nettype wire

// ---- tb/hpc_assertions.sv ----
// Purpose: Port checks for hpc_top
// Assumes: Bound from the bench
// Notes: Port 0 stands for all ports
`timescale 1ns/1ps
`default_nettype none
module hpc_assertions #(
  parameter int PORTS = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_rd_addr,
  input wire logic [7:0] cfg_rd_data,
  input wire logic enumerated,
  input wire logic [PORTS-1:0] hub_power_request,
  input wire logic [PORTS-1:0] overcurrent_sense_low,
  input wire logic [PORTS-1:0] charge_query,
  input wire logic [PORTS-1:0] charge_ack,
  input wire logic [PORTS-1:0] port_power_enable,
  input wire logic charger_detected,
  input wire logic regulator_3v3
);
  logic hub_reg;
  logic hub_next;
  always_comb hub_next = hub_reg | enumerated;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) hub_reg <= 1'b0;
    else hub_reg <= hub_next;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reg_on: assert property ($past(nrst) |-> regulator_3v3) else $error("reg off");
  a_oc_off: assert property (!overcurrent_sense_low[0] [*4] |-> !port_power_enable[0]) else $error("oc power");
  a_oc_rise: assert property ($rose(port_power_enable[0]) |-> $past(overcurrent_sense_low[0], 3)) else $error("rise");
  a_ack_cause: assert property (charge_ack[0] |-> $past(charge_query[0], 3)) else $error("ack");
  a_det_sticky: assert property (charger_detected |=> charger_detected) else $error("detect");
  a_rd_unmapped: assert property (cfg_rd && cfg_rd_addr != 8'hd0 && cfg_rd_addr != 8'hd1
    |=> cfg_rd_data == 8'h00) else $error("rd");
  a_rd_hold: assert property (!cfg_rd |=> $stable(cfg_rd_data)) else $error("rd hold");
  a_hub_power: assert property ($past(hub_reg) && $past(overcurrent_sense_low[0], 3)
    |-> port_power_enable[0] == $past(hub_power_request[0])) else $error("hub");
  c_power: cover property ($rose(port_power_enable[0]));
  c_ack: cover property (charge_ack[0]);
  c_det: cover property ($rose(charger_detected));
endmodule : hpc_assertions
`default_nettype wire

// ---- tb/hpc_partner.sv ----
// Purpose: Host and device model
// Assumes: Bench sets the commands
// Notes: Charger echoes only while driven
`timescale 1ns/1ps
`default_nettype none
module hpc_partner (
  input wire logic up,
  input wire logic chg,
  input wire logic [2:0] want,
  input wire logic [2:0] oc,
  input wire logic p_out,
  input wire logic p_oe,
  output logic [2:0] feat,
  output logic [2:0] req,
  output logic [2:0] ocs,
  output logic pin
);
  assign feat = {3{up}};
  assign req = up ? want : 3'h0;
  assign ocs = ~oc;
  assign pin = chg & p_oe & p_out;
endmodule : hpc_partner
`default_nettype wire

// ---- tb/test_hub_port_charge_power_control.sv ----
// Purpose: Self-checking bench for hpc_top
// Assumes: Three ports, 250 MHz clock
// Notes: Partner stands for host and devices
`timescale 1ns/1ps
`default_nettype none
module test_hub_port_charge_power_control import hpc_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  hpc_cfg_wr_t cfg_wr = '0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_rd_addr = 8'h00;
  logic done = 1'b0;
  logic chg = 1'b0;
  logic up = 1'b0;
  logic [2:0] want = 3'h0, oc = 3'h0, ask = 3'h0;
  logic [7:0] rdd;
  logic [2:0] ppe, ack, feat, req, ocs;
  logic pin, p_out, p_oe, det, r33;
  int n_mismatch = 0;
  int checks = 0;
  always #2 clk = ~clk;
  hpc_top #(.PORTS(3)) u_hpc_top(.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(rdd), .cfg_done(done), .enumerated(up),
    .hub_port_power_feature(feat), .hub_power_request(req), .overcurrent_sense_low(ocs),
    .upstream_plus_pin_in(pin), .upstream_minus_pin_in(pin), .upstream_plus_pin_out(p_out),
    .upstream_plus_pin_oe(p_oe), .upstream_minus_pin_out(), .upstream_minus_pin_oe(), .charge_query(ask),
    .charge_ack(ack), .port_power_enable(ppe), .charger_detected(det), .regulator_3v3(r33));
  hpc_partner u_hpc_partner(.up(up), .chg(chg), .want(want), .oc(oc), .p_out(p_out), .p_oe(p_oe),
    .feat(feat), .req(req), .ocs(ocs), .pin(pin));
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    cfg_wr <= '{1'b1, a, d};
    @(posedge clk);
    cfg_wr.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_rd_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 chk("read data", rdd, exp);
  endtask : rd
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    #1 chk("regulator", 8'(r33), 8'h00);
    idle(6);
    nrst <= 1'b1;
    chg <= 1'b1;
    idle(2);
    chk("regulator", 8'(r33), 8'h01);
    wr(8'hd0, 8'h0a);
    wr(8'h10, 8'hff);
    rd(8'hd0, 8'h0a);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 20 && det !== 1'b1; i++) idle(1);
    chk("detect", 8'(det), 8'h01);
    rd(8'hd1, 8'h01);
    chk("drive off", 8'(p_oe), 8'h00);
    done <= 1'b1;
    idle(1);
    done <= 1'b0;
    wr(8'hd0, 8'hff);
    rd(8'hd0, 8'h0a);
    idle(2);
    chk("power", 8'(ppe), 8'h05);
    ask <= 3'h7;
    idle(4);
    chk("ack", 8'(ack), 8'h05);
    oc <= 3'h1;
    idle(5);
    oc <= 3'h0;
    chk("power", 8'(ppe), 8'h04);
    idle(6);
    chk("power", 8'(ppe), 8'h04);
    want <= 3'h7;
    up <= 1'b1;
    idle(4);
    chk("power", 8'(ppe), 8'h07);
    oc <= 3'h4;
    idle(5);
    chk("power", 8'(ppe[2]), 8'h00);
    nrst <= 1'b0;
    up <= 1'b0;
    oc <= 3'h0;
    idle(1);
    chk("regulator", 8'(r33), 8'h00);
    idle(5);
    nrst <= 1'b1;
    idle(2);
    rd(8'hd0, 8'h00);
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule : test_hub_port_charge_power_control
bind hpc_top hpc_assertions #(.PORTS(PORTS)) u_hpc_assertions(.*);
`default_nettype wire
